//--- inc/xpc_pkg.sv
// shared constants and types of the crosspoint program control block
`default_nettype none
package xpc_pkg;
   localparam int NUM_OUT = 16; // switch outputs
   localparam int SEL_W = 4; // source select width
   localparam int GRP_W = 5; // bits per output group
   localparam int ADDR_W = 4; // parallel output address width
   localparam int CHAIN_BITS = NUM_OUT * GRP_W; // one device in the chain
   localparam int GRP_EN_POS = 0; // enable bit position inside a group
   localparam logic ENABLE_RST = 1'h0; // outputs disabled at reset
   localparam logic PIN_IDLE = 1'h1; // inactive level of low-true pins
   localparam logic TOGGLE_RST = 1'h0; // crossing toggle at reset

   // one output slot as presented on the parallel port
   typedef struct packed {
      logic [SEL_W-1:0] input_select_bits;
      logic output_enable_bit;
   } xpc_slot_t;
endpackage
`default_nettype wire

//--- hw/xpc_top.sv
// crosspoint program control: first-rank shift register, crossing and update latch
// Operation
// - serial/parallel select low puts the device in serial mode.
// - configuration data is taken only while chip select is low.
// - serial data is sampled on each falling program clock edge.
// - each group holds four source bits, then one enable bit.
// - enable low disables the output and its source bits are ignored.
// - update latch is transparent while update and chip select are low.
// - shift register's last bit drives the serial data output.
// - parallel falling edge loads only the addressed slot.
// - several slots load while update is high, then apply together.
// - reset disables every output and restarts the crossing; shift register, shadow and selects keep their values.
`default_nettype none
module xpc_top #(
   parameter int NUM_OUT = xpc_pkg::NUM_OUT
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic prog_clk_in,
   input wire logic chip_select_n_in,
   input wire logic serial_parallel_select_in,
   input wire logic update_n_in,
   input wire logic serial_data_in,
   input wire logic [xpc_pkg::ADDR_W-1:0] output_address_bits_in,
   input wire xpc_pkg::xpc_slot_t parallel_slot_in,
   output logic serial_data_out,
   output logic [NUM_OUT*xpc_pkg::SEL_W-1:0] route_select_out,
   output logic [NUM_OUT-1:0] route_enable_out
);
   localparam int SR_W = NUM_OUT * xpc_pkg::GRP_W;
   localparam int SW = xpc_pkg::SEL_W;
   localparam int GW = xpc_pkg::GRP_W;

   // ---------------- link domain, falling edge of the program clock
   logic [SR_W-1:0] sr_q, sr_d;
   logic tog_q, tog_d;
   logic ser_act, par_act;

   // pins here are launched by the host on this clock, so no synchroniser
   assign ser_act = !chip_select_n_in && !serial_parallel_select_in;
   assign par_act = !chip_select_n_in && serial_parallel_select_in;

   // next shift register: serial shift or addressed slot load
   always_comb begin
      sr_d = sr_q;
      if (ser_act) begin
         sr_d = {sr_q[SR_W-2:0], serial_data_in};
      end else if (par_act) begin
         for (int k = 0; k < NUM_OUT; k++) begin
            if (output_address_bits_in == xpc_pkg::ADDR_W'(k)) begin
               sr_d[k*GW +: GW] = {parallel_slot_in.input_select_bits[0],
                                   parallel_slot_in.input_select_bits[1],
                                   parallel_slot_in.input_select_bits[2],
                                   parallel_slot_in.input_select_bits[3],
                                   parallel_slot_in.output_enable_bit};
            end
         end
      end
      tog_d = tog_q ^ (ser_act || par_act); // flags a fresh first-rank word
   end

   // first rank holds power-up garbage until loaded; reset leaves it alone
   always_ff @(negedge prog_clk_in) begin
      sr_q <= sr_d;
   end

   // the crossing toggle alone needs a known start
   always_ff @(negedge prog_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tog_q <= xpc_pkg::TOGGLE_RST;
      end else begin
         tog_q <= tog_d;
      end
   end

   assign serial_data_out = sr_q[SR_W-1];

   // ---------------- system domain
   logic tog_m_q, tog_s_q, tog_p_q;
   logic upd_m_q, upd_s_q, cs_m_q, cs_s_q;
   logic [SR_W-1:0] shadow_q, shadow_d;
   logic [NUM_OUT*SW-1:0] sel_q, sel_d;
   logic [NUM_OUT-1:0] en_q, en_d;
   logic tog_edge, xp;

   // two-flop synchronisers for toggle, update and chip select
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tog_m_q <= xpc_pkg::TOGGLE_RST;
         tog_s_q <= xpc_pkg::TOGGLE_RST;
         tog_p_q <= xpc_pkg::TOGGLE_RST;
         upd_m_q <= xpc_pkg::PIN_IDLE;
         upd_s_q <= xpc_pkg::PIN_IDLE;
         cs_m_q <= xpc_pkg::PIN_IDLE;
         cs_s_q <= xpc_pkg::PIN_IDLE;
      end else begin
         tog_m_q <= tog_q;
         tog_s_q <= tog_m_q;
         tog_p_q <= tog_s_q;
         upd_m_q <= update_n_in;
         upd_s_q <= upd_m_q;
         cs_m_q <= chip_select_n_in;
         cs_s_q <= cs_m_q;
      end
   end

   assign tog_edge = tog_s_q ^ tog_p_q;
   assign xp = !upd_s_q && !cs_s_q;

   // the first-rank word has been still since its toggle; copy it then
   always_comb begin
      shadow_d = tog_edge ? sr_q : shadow_q;
   end

   always_ff @(posedge clk_in) begin
      shadow_q <= shadow_d;
   end

   // second rank: follows the shadow while the latch is open
   always_comb begin
      sel_d = sel_q;
      en_d = en_q;
      if (xp) begin
         for (int k = 0; k < NUM_OUT; k++) begin
            en_d[k] = shadow_q[k*GW + xpc_pkg::GRP_EN_POS];
            sel_d[k*SW +: SW] = {shadow_q[k*GW+1], shadow_q[k*GW+2],
                                 shadow_q[k*GW+3], shadow_q[k*GW+4]};
         end
      end
   end

   // source selects are not reset; a disabled output ignores them anyway
   always_ff @(posedge clk_in) begin
      sel_q <= sel_d;
   end

   // enables are the only routing state the reset touches; shadow and selects keep theirs
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         en_q <= {NUM_OUT{xpc_pkg::ENABLE_RST}};
      end else begin
         en_q <= en_d;
      end
   end

   assign route_select_out = sel_q;
   assign route_enable_out = en_q;

   // ---------------- checks on the link side
   shift_in_a: assert property (@(negedge prog_clk_in) disable iff (!reset_n_in)
      ser_act |=> sr_q === {$past(sr_q[SR_W-2:0]), $past(serial_data_in)})
      else $error("serial bit not shifted in");

   deselect_hold_a: assert property (@(negedge prog_clk_in)
      disable iff (!reset_n_in)
      chip_select_n_in |=> sr_q === $past(sr_q))
      else $error("shift register moved while deselected");

   chain_out_a: assert property (@(negedge prog_clk_in) disable iff (!reset_n_in)
      ser_act |=> serial_data_out === $past(sr_q[SR_W-2]))
      else $error("serial out not the next register bit");

   slot_load_a: assert property (@(negedge prog_clk_in) disable iff (!reset_n_in)
      par_act |=> sr_q[$past(output_address_bits_in)*GW +: GW] ==
         {$past(parallel_slot_in.input_select_bits[0]),
          $past(parallel_slot_in.input_select_bits[1]),
          $past(parallel_slot_in.input_select_bits[2]),
          $past(parallel_slot_in.input_select_bits[3]),
          $past(parallel_slot_in.output_enable_bit)})
      else $error("addressed slot not loaded");

   slot_count_a: assert property (@(negedge prog_clk_in) disable iff (!reset_n_in)
      par_act |=> $countones(sr_q ^ $past(sr_q)) <= GW)
      else $error("parallel load touched more than one slot");

   // a deselected edge must not move the crossing toggle either
   deselect_tog_a: assert property (@(negedge prog_clk_in) disable iff (!reset_n_in)
      chip_select_n_in |=> tog_q == $past(tog_q))
      else $error("toggle moved while deselected");

   // ---------------- checks on the system side
   reset_off_a: assert property (@(posedge clk_in)
      $rose(reset_n_in) |-> en_q == '0)
      else $error("outputs enabled right after reset");

   latch_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      !xp |=> $stable(en_q) && $stable(sel_q))
      else $error("matrix changed while latch closed");

   latch_follow_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      xp ##1 (xp && $stable(shadow_q)) |=> en_q[0] == $past(shadow_q[xpc_pkg::GRP_EN_POS]))
      else $error("matrix does not follow open latch");

   capture_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (tog_q != tog_s_q) |-> ##[1:4] tog_edge)
      else $error("first-rank change never crossed");

   // the shadow takes the first-rank word on the edge after the toggle shows
   shadow_copy_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      tog_edge |=> shadow_q === $past(sr_q))
      else $error("shadow missed the first-rank word");

   // reset holds every output disabled for as long as it lasts
   reset_clear_a: assert property (@(posedge clk_in)
      !reset_n_in |-> en_q == '0)
      else $error("output enabled during reset");

   // the top output follows its own enable bit through the open latch
   top_enable_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      xp |=> en_q[NUM_OUT-1] == $past(shadow_q[(NUM_OUT-1)*GW + xpc_pkg::GRP_EN_POS]))
      else $error("top output enable not taken from its group");

   // output zero's source index is the group's first four bits, bit zero first
   select_order_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      xp |=> sel_q[SW-1:0] == {$past(shadow_q[1]), $past(shadow_q[2]),
                              $past(shadow_q[3]), $past(shadow_q[4])})
      else $error("source index bits out of order");
endmodule
`default_nettype wire

//--- testbench/xpc_host.sv
// host model driving the programming pins
`default_nettype none
module xpc_host (
   output var logic pclk_out,
   output var logic cs_n_out,
   output var logic ser_out,
   output var logic upd_n_out,
   output var logic data_out,
   output var logic [3:0] addr_out,
   output var xpc_pkg::xpc_slot_t slot_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // pins idle: clock parked high, device deselected
   initial begin
      pclk_out = 1'h1;
      cs_n_out = 1'h1;
      ser_out = 1'h0;
      upd_n_out = 1'h1;
      data_out = 1'h0;
      addr_out = 4'h0;
      slot_out = 5'h00;
   end
   // one falling program clock edge, 48 ns period, kept off the system clock edges
   task automatic pulse();
      #21 pclk_out <= 1'h0;
      #24 pclk_out <= 1'h1;
      #3;
   endtask
   // serial frame, first bit sent is map bit 79
   task automatic send_map(input logic [79:0] map);
      ser_out <= 1'h0;
      upd_n_out <= 1'h1;
      cs_n_out <= 1'h0;
      for (int i = 79; i >= 0; i--) begin
         data_out <= map[i];
         pulse();
      end
      data_out <= ~map[0];
   endtask
   // parallel load of one slot
   task automatic load_slot(input logic [3:0] a, input xpc_pkg::xpc_slot_t s);
      ser_out <= 1'h1;
      upd_n_out <= 1'h1;
      cs_n_out <= 1'h0;
      addr_out <= a;
      slot_out <= s;
      pulse();
   endtask
endmodule
`default_nettype wire

//--- testbench/xpc_top_bench.sv
// testbench of the crosspoint program control block
`default_nettype none
module xpc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'h0;
   logic reset_n_in;
   logic pclk, cs_n, ser, upd_n, sdat, sout;
   logic [3:0] addr;
   xpc_pkg::xpc_slot_t slot;
   logic [63:0] sel, xsel, msk;
   logic [15:0] en, xen;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   // system clock and run limit
   always #4 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   xpc_host host (.pclk_out(pclk), .cs_n_out(cs_n), .ser_out(ser), .upd_n_out(upd_n),
      .data_out(sdat), .addr_out(addr), .slot_out(slot));
   xpc_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .prog_clk_in(pclk),
      .chip_select_n_in(cs_n), .serial_parallel_select_in(ser), .update_n_in(upd_n),
      .serial_data_in(sdat), .output_address_bits_in(addr), .parallel_slot_in(slot),
      .serial_data_out(sout), .route_select_out(sel), .route_enable_out(en));
   // compare one value
   task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", what, e, g);
      end
   endtask
   // open the latch and compare the enables and the selects of enabled outputs
   task automatic apply_chk();
      host.upd_n_out <= 1'h0;
      repeat (10) @(posedge clk_in);
      for (int k = 0; k < 16; k++) msk[4*k +: 4] = {4{xen[k]}};
      chk("enable", 64'(xen), 64'(en));
      chk("select", xsel & msk, sel & msk);
   endtask
   // full serial map, then update
   task automatic t_serial();
      logic [79:0] map;
      xen = 16'hA5C3;
      for (int k = 0; k < 16; k++) begin
         xsel[4*k +: 4] = 4'(15 - k);
         map[5*k +: 5] = {xsel[4*k], xsel[4*k+1], xsel[4*k+2], xsel[4*k+3], xen[k]};
      end
      host.send_map(map);
      chk("data out", 64'(map[79]), 64'(sout));
      apply_chk();
   endtask
   // two slots loaded, matrix waits for update
   task automatic t_parallel();
      host.load_slot(4'h2, 5'h1D);
      host.load_slot(4'h0, 5'h14);
      repeat (10) @(posedge clk_in);
      chk("held", 64'(xen), 64'(en));
      chk("held select", xsel & msk, sel & msk);
      xsel[11:8] = 4'hE;
      xen[2] = 1'h1;
      xen[0] = 1'h0;
      apply_chk();
   endtask
   // reset disables outputs only
   task automatic t_reset();
      reset_n_in <= 1'h0;
      repeat (2) @(posedge clk_in);
      chk("reset", 64'h0, 64'(en));
      chk("reset select", xsel & msk, sel & msk);
      chk("reset out", 64'(xsel[60]), 64'(sout));
      reset_n_in <= 1'h1;
      repeat (10) @(posedge clk_in);
      chk("kept", 64'(xen), 64'(en));
   endtask
   // deselected clock edges leave the shift register alone
   task automatic t_deselect();
      host.cs_n_out <= 1'h1;
      host.ser_out <= 1'h0;
      host.data_out <= ~xsel[60];
      repeat (4) host.pulse();
      chk("deselect out", 64'(xsel[60]), 64'(sout));
      host.cs_n_out <= 1'h0;
      apply_chk();
   endtask
   // print counts and verdict
   task automatic end_sim();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      reset_n_in <= 1'h0;
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'h1;
      t_serial();
      t_parallel();
      t_reset();
      t_deselect();
      end_sim();
   end
endmodule
`default_nettype wire
